/* File: video_cfg_pkg.sv */
package video_cfg_pkg;

	// ==========================================================
	// register indices (byte address = 4 * index)
	localparam logic [5:0] IDX_GREEN_GAIN   = 6'h07;
	localparam logic [5:0] IDX_BLUE_GAIN    = 6'h08;
	localparam logic [5:0] IDX_RED_OFFSET   = 6'h09;
	localparam logic [5:0] IDX_GREEN_OFFSET = 6'h0a;
	localparam logic [5:0] IDX_BLUE_OFFSET  = 6'h0b;
	localparam logic [5:0] IDX_OFFSET_SETUP = 6'h0c;
	localparam logic [5:0] IDX_FILTER_SETUP = 6'h0d;
	localparam logic [5:0] IDX_LINE_HIGH    = 6'h0e;
	localparam logic [5:0] IDX_LINE_LOW     = 6'h0f;
	localparam logic [5:0] IDX_SAMPLE_PHASE = 6'h10;
	localparam logic [5:0] IDX_HOLD_BEFORE  = 6'h11;
	localparam logic [5:0] IDX_HOLD_AFTER   = 6'h12;
	localparam logic [5:0] IDX_LOCK_OPTIONS = 6'h13;
	localparam logic [5:0] IDX_STATUS       = 6'h20;

	// ==========================================================
	// reset values
	localparam logic [7:0] RST_GAIN          = 8'h55;
	localparam logic [7:0] RST_OFFSET        = 8'h80;
	localparam logic [7:0] RST_OFFSET_SETUP  = 8'h00;
	localparam logic [7:0] RST_FILTER_SETUP  = 8'h0e;
	localparam logic [5:0] RST_LINE_HIGH     = 6'h03;
	localparam logic [7:0] RST_LINE_LOW      = 8'h20;
	localparam logic [5:0] RST_SAMPLE_PHASE  = 6'h00;
	localparam logic [7:0] RST_HOLD_BEFORE   = 8'h08;
	localparam logic [7:0] RST_HOLD_AFTER    = 8'h00;
	localparam logic [1:0] RST_LOCK_OPTIONS  = 2'h0;

	// ==========================================================
	// field positions
	localparam int unsigned RANGE_BIT        = 0;
	localparam int unsigned RED_LSB_POS      = 2;
	localparam int unsigned GREEN_LSB_POS    = 4;
	localparam int unsigned BLUE_LSB_POS     = 6;
	localparam int unsigned CORNER_POS       = 1;
	localparam int unsigned PEAKING_POS      = 4;
	localparam int unsigned LOCK_FIRST_BIT   = 0;
	localparam int unsigned LOCK_SECOND_BIT  = 1;
	localparam int unsigned STAT_SHORT_BIT   = 0;
	localparam int unsigned STAT_HOLD_BIT    = 1;

	// ==========================================================
	// arithmetic constants
	localparam logic [8:0]  GAIN_BASE        = 9'h055; // gain = (85 + code) / 170
	localparam logic [13:0] LINE_LENGTH_MIN  = 14'h0200;
	localparam logic [1:0]  RESP_OKAY        = 2'h0;
	localparam logic [1:0]  RESP_SLVERR      = 2'h2;

	// ==========================================================
	// carriers
	typedef struct packed {
		logic [7:0] code;
		logic [8:0] ratio;      // gain in units of 1/170 v/v
	} gain_t;

	typedef struct packed {
		logic [9:0] dac_word;   // analog offset converter word
		logic [7:0] digital;    // two's complement digital offset
	} level_t;

	typedef struct packed {
		logic [2:0] corner;
		logic [3:0] peaking;
	} filter_t;

endpackage

/* File: video_cfg_properties.sv */
module video_cfg_properties (
	input wire logic                   aclk, aresetn, awvalid, awready, wvalid, wready,
	input wire logic                   bvalid, bready, arvalid, arready, rvalid, rready,
	input wire logic                   external_clamp_select, clamp_pulse, pll_line_length_load,
	input wire logic [13:0]            pll_line_length,
	input wire video_cfg_pkg::gain_t   green_gain,
	input wire video_cfg_pkg::level_t  red_level
);
	// ==========================================================
	// output relations and bus handshakes
	default clocking cb @(posedge aclk); endclocking
	default disable iff (!aresetn);
	AST_GAIN_RATIO: assert property (green_gain.ratio == 9'(green_gain.code) + 9'h055)
		else $error("gain ratio does not follow code");
	AST_DIGITAL_OFFSET: assert property
		(red_level.digital == {~red_level.dac_word[9], red_level.dac_word[8:2]})
		else $error("digital offset does not match converter byte");
	AST_LOAD_PULSE: assert property (pll_line_length_load |=> !pll_line_length_load)
		else $error("line length load longer than one cycle");
	AST_LOAD_ONLY: assert property ($changed(pll_line_length) |-> pll_line_length_load)
		else $error("line length changed without load");
	AST_CLAMP_GATE: assert property
		($past(external_clamp_select) && !($past(clamp_pulse) && !$past(clamp_pulse, 2))
		|-> $stable(red_level)) else $error("level moved outside clamp edge");
	AST_WRITE_ANSWER: assert property (awvalid && awready && wvalid && wready |-> ##2 bvalid)
		else $error("write response late");
	AST_B_HOLD: assert property (bvalid && !bready |=> bvalid)
		else $error("write response dropped");
	AST_READ_ANSWER: assert property (arvalid && arready |=> rvalid)
		else $error("read data late");
	AST_R_HOLD: assert property (rvalid && !rready |=> rvalid)
		else $error("read data dropped");
	cover property (pll_line_length_load);
	cover property (external_clamp_select && $rose(clamp_pulse));
	cover property (bvalid && bready);
endmodule

bind video_digitizer_config_regs video_cfg_properties chk_u (.*);

/* File: video_digitizer_config_regs.sv */
// Summary of operation
// - gain code 0x00 half, 0x55 unity, 0xff double gain
// - auto black level on: offset byte is digital offset, one code per step
// - offset byte is offset-binary: 0x00 is -0x80, 0x80 zero, 0xff +0x7f
// - auto black level off: offset byte drives upper eight converter bits
// - offset setup bits 3:2, 5:4, 7:6 are red, green, blue low converter bits
// - offset setup bit 0 selects half or quarter full-scale range
// - filter bits 3:1 pick lowpass corner, 111 default, bit 0 ignored
// - filter bits 7:4 set peaking, 0000 disables and is reset value
// - line length is 14 bits: high bits 5:0 above low byte
// - line length reaches the pll only on a low byte write
// - six-bit phase moves sample point in sixty-fourths of a pixel
// - internal hold starts programmed lines before frame sync begins
// - internal hold lasts programmed lines after frame sync ends
// - lock option bit 0 picks first line sync edge, clear is trailing
// - lock option bit 1 picks second line sync edge, clear is trailing
// - with external clamp, converter values change only on clamp leading edge
//
// The AXI4-Lite register port was chosen for this implementation.
module video_digitizer_config_regs #(
	parameter int unsigned ADDR_W = 8,
	parameter int unsigned LINE_W = 12
) (
	input  wire logic                           aclk,
	input  wire logic                           aresetn,
	input  wire logic                           awvalid,
	output logic                                awready,
	input  wire logic [ADDR_W-1:0]              awaddr,
	input  wire logic [2:0]                     awprot,
	input  wire logic                           wvalid,
	output logic                                wready,
	input  wire logic [31:0]                    wdata,
	input  wire logic [3:0]                     wstrb,
	output logic                                bvalid,
	input  wire logic                           bready,
	output logic [1:0]                          bresp,
	input  wire logic                           arvalid,
	output logic                                arready,
	input  wire logic [ADDR_W-1:0]              araddr,
	input  wire logic [2:0]                     arprot,
	output logic                                rvalid,
	input  wire logic                           rready,
	output logic [31:0]                         rdata,
	output logic [1:0]                          rresp,
	input  wire logic                           black_level_auto,
	input  wire logic                           external_clamp_select,
	input  wire logic                           clamp_pulse,
	input  wire logic                           first_line_sync_input,
	input  wire logic                           second_line_sync_input,
	input  wire logic                           line_sync_select,
	input  wire logic                           frame_sync,
	input  wire logic                           external_hold_select,
	input  wire logic                           external_hold,
	output video_cfg_pkg::gain_t                green_gain,
	output video_cfg_pkg::gain_t                blue_gain,
	output video_cfg_pkg::level_t               red_level,
	output video_cfg_pkg::level_t               green_level,
	output video_cfg_pkg::level_t               blue_level,
	output logic                                level_is_digital,
	output logic                                offset_range_quarter,
	output video_cfg_pkg::filter_t              frontend_corner_select,
	output logic [13:0]                         pll_line_length,
	output logic                                pll_line_length_load,
	output logic [5:0]                          sample_phase_out,
	output logic                                pll_lock_pulse,
	output logic                                pll_hold
);

	// elaboration checks on the parameters
	if (ADDR_W < 8 || ADDR_W > 32) $error("ADDR_W must be 8..32");
	if (LINE_W < 9 || LINE_W > 16) $error("LINE_W must be 9..16");

	// ==========================================================
	// register storage
	logic [7:0]        green_channel_gain;
	logic [7:0]        blue_channel_gain;
	logic [7:0]        red_channel_offset;
	logic [7:0]        green_channel_offset;
	logic [7:0]        blue_channel_offset;
	logic [7:0]        offset_converter_setup;
	logic [7:0]        frontend_filter_setup;
	logic [5:0]        line_length_high;
	logic [7:0]        line_length_low;
	logic [5:0]        sample_phase;
	logic [7:0]        hold_lines_before_frame;
	logic [7:0]        hold_lines_after_frame;
	logic [1:0]        pll_lock_options;
	logic              line_length_short;

	// ==========================================================
	// bus slave state
	logic              aw_held;
	logic              w_held;
	logic [5:0]        aw_index;
	logic [31:0]       w_data;
	logic              w_lane0;
	logic              do_write;
	logic              ar_take;

	// true when the index names a register of this block
	function automatic logic is_mapped(input logic [5:0] idx);
		is_mapped = (idx >= video_cfg_pkg::IDX_GREEN_GAIN &&
			idx <= video_cfg_pkg::IDX_LOCK_OPTIONS) || idx == video_cfg_pkg::IDX_STATUS;
	endfunction

	// offset-binary byte to two's complement by flipping the sign bit
	function automatic logic [7:0] to_twos(input logic [7:0] code);
		to_twos = {~code[7], code[6:0]};
	endfunction

	// channel gain code to gain in 1/170 steps
	function automatic logic [8:0] gain_ratio(input logic [7:0] code);
		gain_ratio = video_cfg_pkg::GAIN_BASE + {1'b0, code};
	endfunction

	// handshakes: each address and data slot takes one item until the write retires
	assign awready  = ~aw_held;
	assign wready   = ~w_held;
	assign do_write = aw_held & w_held & ~bvalid;
	assign arready  = ~rvalid;
	assign ar_take  = arvalid & ~rvalid;

	// write address slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_held  <= 1'b0;
			aw_index <= 6'h00;
		end else if (awvalid && !aw_held) begin
			aw_held  <= 1'b1;
			aw_index <= awaddr[7:2];
		end else if (do_write) begin
			aw_held  <= 1'b0;
		end
	end

	// write data slot
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			w_held  <= 1'b0;
			w_data  <= 32'h0000_0000;
			w_lane0 <= 1'b0;
		end else if (wvalid && !w_held) begin
			w_held  <= 1'b1;
			w_data  <= wdata;
			w_lane0 <= wstrb[0];
		end else if (do_write) begin
			w_held  <= 1'b0;
		end
	end

	// write response, error for an unmapped index; address bits above bit 7 are not decoded
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			bvalid <= 1'b0;
			bresp  <= video_cfg_pkg::RESP_OKAY;
		end else if (do_write) begin
			bvalid <= 1'b1;
			bresp  <= is_mapped(aw_index) ? video_cfg_pkg::RESP_OKAY
				: video_cfg_pkg::RESP_SLVERR;
		end else if (bready) begin
			bvalid <= 1'b0;
		end
	end

	// ==========================================================
	// register writes; only byte lane 0 carries data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			green_channel_gain      <= video_cfg_pkg::RST_GAIN;
			blue_channel_gain       <= video_cfg_pkg::RST_GAIN;
			red_channel_offset      <= video_cfg_pkg::RST_OFFSET;
			green_channel_offset    <= video_cfg_pkg::RST_OFFSET;
			blue_channel_offset     <= video_cfg_pkg::RST_OFFSET;
			offset_converter_setup  <= video_cfg_pkg::RST_OFFSET_SETUP;
			frontend_filter_setup   <= video_cfg_pkg::RST_FILTER_SETUP;
			line_length_high        <= video_cfg_pkg::RST_LINE_HIGH;
			line_length_low         <= video_cfg_pkg::RST_LINE_LOW;
			sample_phase            <= video_cfg_pkg::RST_SAMPLE_PHASE;
			hold_lines_before_frame <= video_cfg_pkg::RST_HOLD_BEFORE;
			hold_lines_after_frame  <= video_cfg_pkg::RST_HOLD_AFTER;
			pll_lock_options        <= video_cfg_pkg::RST_LOCK_OPTIONS;
		end else if (do_write && w_lane0 && aw_held) begin
			unique case (aw_index)
				video_cfg_pkg::IDX_GREEN_GAIN:   green_channel_gain   <= w_data[7:0];
				video_cfg_pkg::IDX_BLUE_GAIN:    blue_channel_gain    <= w_data[7:0];
				video_cfg_pkg::IDX_RED_OFFSET:   red_channel_offset   <= w_data[7:0];
				video_cfg_pkg::IDX_GREEN_OFFSET: green_channel_offset <= w_data[7:0];
				video_cfg_pkg::IDX_BLUE_OFFSET:  blue_channel_offset  <= w_data[7:0];
				video_cfg_pkg::IDX_OFFSET_SETUP:
					offset_converter_setup <= w_data[7:0] & 8'hfd;
				video_cfg_pkg::IDX_FILTER_SETUP:
					frontend_filter_setup  <= w_data[7:0] & 8'hfe;
				video_cfg_pkg::IDX_LINE_HIGH:    line_length_high     <= w_data[5:0];
				video_cfg_pkg::IDX_LINE_LOW:     line_length_low      <= w_data[7:0];
				video_cfg_pkg::IDX_SAMPLE_PHASE: sample_phase         <= w_data[5:0];
				video_cfg_pkg::IDX_HOLD_BEFORE:  hold_lines_before_frame <= w_data[7:0];
				video_cfg_pkg::IDX_HOLD_AFTER:   hold_lines_after_frame  <= w_data[7:0];
				video_cfg_pkg::IDX_LOCK_OPTIONS:
					pll_lock_options <= w_data[1:0];
				default: ;
			endcase
		end
	end

	// ==========================================================
	// read path, answered one cycle after the address is taken
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			rvalid <= 1'b0;
			rdata  <= 32'h0000_0000;
			rresp  <= video_cfg_pkg::RESP_OKAY;
		end else if (ar_take) begin
			rvalid <= 1'b1;
			rresp  <= is_mapped(araddr[7:2]) ? video_cfg_pkg::RESP_OKAY
				: video_cfg_pkg::RESP_SLVERR;
			unique case (araddr[7:2])
				video_cfg_pkg::IDX_GREEN_GAIN:   rdata <= {24'h0, green_channel_gain};
				video_cfg_pkg::IDX_BLUE_GAIN:    rdata <= {24'h0, blue_channel_gain};
				video_cfg_pkg::IDX_RED_OFFSET:   rdata <= {24'h0, red_channel_offset};
				video_cfg_pkg::IDX_GREEN_OFFSET: rdata <= {24'h0, green_channel_offset};
				video_cfg_pkg::IDX_BLUE_OFFSET:  rdata <= {24'h0, blue_channel_offset};
				video_cfg_pkg::IDX_OFFSET_SETUP: rdata <= {24'h0, offset_converter_setup};
				video_cfg_pkg::IDX_FILTER_SETUP: rdata <= {24'h0, frontend_filter_setup};
				video_cfg_pkg::IDX_LINE_HIGH:    rdata <= {26'h0, line_length_high};
				video_cfg_pkg::IDX_LINE_LOW:     rdata <= {24'h0, line_length_low};
				video_cfg_pkg::IDX_SAMPLE_PHASE: rdata <= {26'h0, sample_phase};
				video_cfg_pkg::IDX_HOLD_BEFORE:  rdata <= {24'h0, hold_lines_before_frame};
				video_cfg_pkg::IDX_HOLD_AFTER:   rdata <= {24'h0, hold_lines_after_frame};
				video_cfg_pkg::IDX_LOCK_OPTIONS: rdata <= {30'h0, pll_lock_options};
				video_cfg_pkg::IDX_STATUS:       rdata <= {30'h0, pll_hold, line_length_short};
				default:                         rdata <= 32'h0000_0000;
			endcase
		end else if (rready) begin
			rvalid <= 1'b0;
		end
	end

	// ==========================================================
	// gain outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			green_gain <= '{code: video_cfg_pkg::RST_GAIN,
				ratio: gain_ratio(video_cfg_pkg::RST_GAIN)};
			blue_gain  <= '{code: video_cfg_pkg::RST_GAIN,
				ratio: gain_ratio(video_cfg_pkg::RST_GAIN)};
		end else begin
			green_gain <= '{code: green_channel_gain, ratio: gain_ratio(green_channel_gain)};
			blue_gain  <= '{code: blue_channel_gain, ratio: gain_ratio(blue_channel_gain)};
		end
	end

	// ==========================================================
	// offset outputs, gated by the clamp leading edge when the clamp is external
	logic              clamp_prev;
	logic              offset_apply;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			clamp_prev <= 1'b0;
		end else begin
			clamp_prev <= clamp_pulse;
		end
	end

	assign offset_apply = ~external_clamp_select | (clamp_pulse & ~clamp_prev);

	// converter word: byte on top, low pair from the setup register
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			red_level            <= '{dac_word: {video_cfg_pkg::RST_OFFSET, 2'b00},
				digital: to_twos(video_cfg_pkg::RST_OFFSET)};
			green_level          <= '{dac_word: {video_cfg_pkg::RST_OFFSET, 2'b00},
				digital: to_twos(video_cfg_pkg::RST_OFFSET)};
			blue_level           <= '{dac_word: {video_cfg_pkg::RST_OFFSET, 2'b00},
				digital: to_twos(video_cfg_pkg::RST_OFFSET)};
			offset_range_quarter <= 1'b0;
			level_is_digital     <= 1'b0;
		end else if (offset_apply) begin
			red_level.dac_word   <= {red_channel_offset,
				offset_converter_setup[video_cfg_pkg::RED_LSB_POS +: 2]};
			green_level.dac_word <= {green_channel_offset,
				offset_converter_setup[video_cfg_pkg::GREEN_LSB_POS +: 2]};
			blue_level.dac_word  <= {blue_channel_offset,
				offset_converter_setup[video_cfg_pkg::BLUE_LSB_POS +: 2]};
			red_level.digital    <= to_twos(red_channel_offset);
			green_level.digital  <= to_twos(green_channel_offset);
			blue_level.digital   <= to_twos(blue_channel_offset);
			offset_range_quarter <= offset_converter_setup[video_cfg_pkg::RANGE_BIT];
			level_is_digital     <= black_level_auto;
		end
	end

	// ==========================================================
	// front end filter and sample phase
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frontend_corner_select <= '{corner: video_cfg_pkg::RST_FILTER_SETUP[3:1],
				peaking: video_cfg_pkg::RST_FILTER_SETUP[7:4]};
			sample_phase_out       <= video_cfg_pkg::RST_SAMPLE_PHASE;
		end else begin
			frontend_corner_select.corner  <=
				frontend_filter_setup[video_cfg_pkg::CORNER_POS +: 3];
			frontend_corner_select.peaking <=
				frontend_filter_setup[video_cfg_pkg::PEAKING_POS +: 4];
			sample_phase_out       <= sample_phase;
		end
	end

	// ==========================================================
	// line length to the pll, loaded only by a low byte write
	logic              low_written;

	assign low_written = do_write && w_lane0 && aw_index == video_cfg_pkg::IDX_LINE_LOW;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_line_length      <= {video_cfg_pkg::RST_LINE_HIGH, video_cfg_pkg::RST_LINE_LOW};
			pll_line_length_load <= 1'b0;
			line_length_short    <= 1'b0;
		end else begin
			pll_line_length_load <= low_written;
			if (low_written) begin
				pll_line_length   <= {line_length_high, w_data[7:0]};
				line_length_short <= {line_length_high, w_data[7:0]}
					< video_cfg_pkg::LINE_LENGTH_MIN;
			end
		end
	end

	// ==========================================================
	// lock edge selection on the active line sync input
	logic              first_prev;
	logic              second_prev;
	logic              lock_first;
	logic              lock_second;

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			first_prev  <= 1'b0;
			second_prev <= 1'b0;
		end else begin
			first_prev  <= first_line_sync_input;
			second_prev <= second_line_sync_input;
		end
	end

	// leading edge is the rise, trailing edge the fall
	assign lock_first  = pll_lock_options[video_cfg_pkg::LOCK_FIRST_BIT]
		? (first_line_sync_input & ~first_prev)
		: (~first_line_sync_input & first_prev);
	assign lock_second = pll_lock_options[video_cfg_pkg::LOCK_SECOND_BIT]
		? (second_line_sync_input & ~second_prev)
		: (~second_line_sync_input & second_prev);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_lock_pulse <= 1'b0;
		end else begin
			pll_lock_pulse <= line_sync_select ? lock_second : lock_first;
		end
	end

	// ==========================================================
	// internal pll hold around frame sync, counted in lock pulses
	logic              frame_prev;
	logic [LINE_W-1:0] line_count;
	logic [LINE_W-1:0] frame_lines;
	logic              frame_known;
	logic [7:0]        after_left;
	logic [LINE_W:0]   reach;
	logic              hold_internal;

	// line count plus lines to hold before frame sync, compared with the last frame's line count
	assign reach = {1'b0, line_count} + {{(LINE_W-7){1'b0}}, hold_lines_before_frame};

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			frame_prev  <= 1'b0;
			line_count  <= '0;
			frame_lines <= '0;
			frame_known <= 1'b0;
		end else begin
			frame_prev <= frame_sync;
			if (frame_sync && !frame_prev) begin
				frame_lines <= line_count;
				frame_known <= 1'b1;
				line_count  <= '0;
			end else if (pll_lock_pulse && line_count != '1) begin
				line_count  <= line_count + 1'b1;
			end
		end
	end

	// lines still to hold after frame sync ends
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			after_left <= 8'h00;
		end else if (!frame_sync && frame_prev) begin
			after_left <= hold_lines_after_frame;
		end else if (pll_lock_pulse && after_left != 8'h00) begin
			after_left <= after_left - 8'h01;
		end
	end

	assign hold_internal = frame_sync | (after_left != 8'h00)
		| (frame_known && reach >= {1'b0, frame_lines});

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pll_hold <= 1'b0;
		end else begin
			pll_hold <= external_hold_select ? external_hold : hold_internal;
		end
	end

endmodule

/* File: video_digitizer_config_regs_bench.sv */
module video_digitizer_config_regs_bench;
	timeunit 1ns;
	timeprecision 100ps;
	logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready;
	logic rvalid, rready, level_is_digital, offset_range_quarter, black_level_auto;
	logic external_clamp_select, clamp_pulse, line_sync_select, first_line_sync_input;
	logic second_line_sync_input, frame_sync, external_hold_select, external_hold;
	logic pll_line_length_load, pll_lock_pulse, pll_hold;
	logic [7:0]                awaddr, araddr, d;
	logic [2:0]                awprot, arprot;
	logic [31:0]               wdata, rdata, q;
	logic [3:0]                wstrb;
	logic [1:0]                bresp, rresp, r;
	logic [13:0]               pll_line_length;
	logic [5:0]                sample_phase_out;
	video_cfg_pkg::gain_t      green_gain, blue_gain;
	video_cfg_pkg::level_t     red_level, green_level, blue_level;
	video_cfg_pkg::filter_t    frontend_corner_select;
	int                        error_cnt, checks, cyc, seed, n, loads;
	logic [7:0]                model [0:63];
	logic [7:0] mask [7:19] = '{8'hff, 8'hff, 8'hff, 8'hff, 8'hff, 8'hfd, 8'hfe, 8'h3f,
		8'hff, 8'h3f, 8'hff, 8'hff, 8'h03};
	logic [7:0] rst [7:19] = '{8'h55, 8'h55, 8'h80, 8'h80, 8'h80, 8'h00, 8'h0e, 8'h03,
		8'h20, 8'h00, 8'h08, 8'h00, 8'h00};

	video_digitizer_config_regs dut_u (.*);

	// ==========================================================
	// clock and run limit
	initial begin
		aclk = 1'b0;
		forever #4 aclk = ~aclk;
	end
	always @(posedge aclk) begin
		cyc <= cyc + 1;
		if (pll_line_length_load === 1'b1) loads <= loads + 1;
		if (cyc == 20000) begin
			error_cnt++;
			close_out;
		end
	end

	// ==========================================================
	// helpers
	task automatic close_out;
		$display("checks %0d mismatches %0d", checks, error_cnt);
		if (error_cnt == 0 && checks > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, g);
		checks++;
		if (g !== e) begin
			error_cnt++;
			$display("BAD %s exp %h got %h", nm, e, g);
		end
	endtask
	function automatic logic [17:0] lvl(input logic [7:0] o, input logic [1:0] l);
		return {o, l, o ^ 8'h80};
	endfunction
	task automatic settle;
		repeat (3) @(posedge aclk);
		@(negedge aclk);
	endtask
	// write: release each channel once taken, response checked against map
	task automatic wr(input logic [5:0] i, input logic [7:0] dt);
		logic a, w, b;
		a = 1'b0;
		w = 1'b0;
		b = 1'b0;
		@(posedge aclk);
		awvalid <= 1'b1;
		wvalid  <= 1'b1;
		bready  <= 1'b1;
		awaddr  <= {i, 2'h0};
		wdata   <= {24'h0, dt};
		while (!b) begin
			@(negedge aclk);
			a = a | awready;
			w = w | wready;
			b = bvalid;
			r = bresp;
			@(posedge aclk);
			if (a) awvalid <= 1'b0;
			if (w) wvalid <= 1'b0;
		end
		bready <= 1'b0;
		if (i > 6 && i < 20) begin
			chk("bresp", 0, r);
			if (wstrb[0]) model[i] = dt & mask[i];
		end else chk("bresp", 2, r);
	endtask
	task automatic rd(input logic [5:0] i);
		logic t, b;
		t = 1'b0;
		b = 1'b0;
		@(posedge aclk);
		arvalid <= 1'b1;
		rready  <= 1'b1;
		araddr  <= {i, 2'h0};
		while (!b) begin
			@(negedge aclk);
			t = t | arready;
			b = rvalid;
			q = rdata;
			r = rresp;
			@(posedge aclk);
			if (t) arvalid <= 1'b0;
		end
		rready <= 1'b0;
	endtask
	task automatic rdall;
		for (int k = 7; k < 20; k++) begin
			rd(6'(k));
			chk("reg", {24'h0, model[k]}, q);
		end
	endtask
	task automatic outs;
		settle;
		chk("green_gain", {model[7], 9'(model[7]) + 9'h055}, green_gain);
		chk("blue_gain", {model[8], 9'(model[8]) + 9'h055}, blue_gain);
		chk("red", lvl(model[9], model[12][3:2]), red_level);
		chk("green", lvl(model[10], model[12][5:4]), green_level);
		chk("blue", lvl(model[11], model[12][7:6]), blue_level);
		chk("range", model[12][0], offset_range_quarter);
		chk("filter", {model[13][3:1], model[13][7:4]}, frontend_corner_select);
		chk("phase", model[16][5:0], sample_phase_out);
		chk("digital", black_level_auto, level_is_digital);
	endtask
	task automatic sync(input logic lv, input logic e);
		logic [31:0] c;
		c = 0;
		@(posedge aclk);
		first_line_sync_input  <= lv;
		second_line_sync_input <= lv;
		repeat (4) begin
			@(negedge aclk);
			c += pll_lock_pulse;
		end
		chk("lock", e, c);
	endtask

	// ==========================================================
	// main sequence
	initial begin
		{aresetn, awvalid, wvalid, bready, arvalid, rready, awaddr, araddr, awprot, arprot,
			wdata, black_level_auto, external_clamp_select, clamp_pulse, line_sync_select,
			first_line_sync_input, second_line_sync_input, frame_sync, external_hold_select,
			external_hold} = '0;
		wstrb = 4'hf;
		seed = 32'hb2f7540e;
		for (n = 7; n < 20; n++) model[n] = rst[n];
		repeat (12) @(posedge aclk);
		aresetn <= 1'b1;
		rdall;
		outs;
		chk("line", 14'h0320, pll_line_length);
		for (n = 7; n < 20; n++) wr(6'(n), 8'($random(seed)) | (n == 14 ? 8'h02 : 8'h00));
		black_level_auto <= 1'b1;
		outs;
		rdall;
		chk("line", {model[14][5:0], model[15]}, pll_line_length);
		wr(7, 8'h00);
		wr(8, 8'hff);
		outs;
		d = model[14];
		wr(14, 8'h2a);
		settle;
		chk("line", {d[5:0], model[15]}, pll_line_length);
		wr(15, 8'h11);
		wstrb <= 4'he;
		settle;
		chk("line", 14'h2a11, pll_line_length);
		wr(8, 8'h33);
		wstrb <= 4'hf;
		wr(6'h3f, 8'h5a);
		rd(6'h3f);
		chk("rresp", 2, r);
		chk("rdata", 0, q);
		rdall;
		for (n = 0; n < 4; n++) begin
			wr(19, 8'(n % 2) << (n / 2));
			line_sync_select <= n[1];
			sync(1'b1, n[0]);
			sync(1'b0, !n[0]);
		end
		// two frames six lines apart, then hold two lines before and one after
		wr(17, 8'h02);
		wr(18, 8'h01);
		for (n = 0; n < 12; n++) begin
			if (n == 0 || n == 7) begin
				@(posedge aclk);
				frame_sync <= 1'b1;
				@(posedge aclk);
				frame_sync <= 1'b0;
				settle;
			end else begin
				sync(1'b1, 1'b1);
				sync(1'b0, 1'b0);
			end
			if (n > 6) chk("hold", n == 7 || n == 11, pll_hold);
		end
		@(posedge aclk);
		external_hold_select <= 1'b1;
		settle;
		chk("hold", 0, pll_hold);
		@(posedge aclk);
		external_clamp_select <= 1'b1;
		d = model[9];
		wr(9, 8'h11);
		settle;
		chk("red", lvl(d, model[12][3:2]), red_level);
		@(posedge aclk);
		clamp_pulse <= 1'b1;
		settle;
		chk("red", lvl(8'h11, model[12][3:2]), red_level);
		chk("loads", 2, loads);
		close_out;
	end
endmodule
